// File: common/pmit_pkg.sv
// package for the power-management status mirrors and idle timer 1
// assumes a 100 MHz system clock and an 8-bit configuration port
package pmit_pkg;

  // configuration register indices
  localparam logic [7:0] TRAP_MIRROR_IDX = 8'h86;
  localparam logic [7:0] MISC_MIRROR_IDX = 8'h87;
  localparam logic [7:0] TMR1_COUNT_IDX = 8'h88;
  localparam logic [7:0] TMR1_CTRL_IDX = 8'h89;
  localparam logic [7:0] TRAP_CLEAR_IDX = 8'hF6;
  localparam logic [7:0] MISC_CLEAR_IDX = 8'hF7;

  // values after reset
  localparam logic [7:0] TMR1_COUNT_RST = 8'h00;
  localparam logic [7:0] TMR1_CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // field positions
  localparam int TRAP_VIDEO_BIT = 7;
  localparam int TRAP_SEC_HD_BIT = 5;
  localparam int TRAP_SEC_IDLE_BIT = 4;
  localparam int TRAP_KBD_BIT = 3;
  localparam int TRAP_PAR_SER_BIT = 2;
  localparam int TRAP_FLOPPY_BIT = 1;
  localparam int TRAP_PRI_HD_BIT = 0;
  localparam int MISC_GP0_BIT = 5;
  localparam int MISC_LID_POS_BIT = 4;
  localparam int MISC_LID_SMI_BIT = 3;
  localparam int MISC_CODEC_BIT = 2;
  localparam int MISC_RTC_BIT = 1;
  localparam int MISC_ACPI_BIT = 0;
  localparam int CTRL_TIMEBASE_BIT = 7;
  localparam int CTRL_RETRIG_W = 7;

  // timebase: 1 ms tick from the system clock, 1 s from 1000 ms ticks
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TICK_NS = 1000000;
  localparam int MS_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmit_cfg_req_t;

  typedef struct packed {
    logic video;
    logic sec_hd;
    logic sec_hd_idle;
    logic kbd_mouse;
    logic par_ser;
    logic floppy;
    logic pri_hd;
  } pmit_trap_evt_t;

  typedef struct packed {
    logic [2:0] gp_sel;
    logic [2:0] gp_dir;
    logic [2:0] gp_smi_en;
    logic lid_dir;
    logic lid_sel;
  } pmit_pin_cfg_t;

endpackage : pmit_pkg

// File: hw/pmit_sticky.sv
// sticky status bits: a set pulse latches, a clear pulse drops them
// assumes set and clear are synchronous one-cycle pulses
`timescale 1ns/100ps
module pmit_sticky #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic [W-1:0] set,
  input wire logic clr,
  // state
  output logic [W-1:0] q
);

  // a set in the clearing cycle survives
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= (q & ~{W{clr}}) | set;
  end

endmodule : pmit_sticky

// File: hw/pmit_tick_gen.sv
// free-running prescaler giving millisecond and second ticks
// assumes clk_sys runs continuously
`timescale 1ns/100ps
module pmit_tick_gen #(
  parameter int MS_CYC = pmit_pkg::MS_CYCLES,
  parameter int MS_PER_S = pmit_pkg::MS_PER_S
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // ticks, one cycle each
  output logic ms_tick_q,
  output logic s_tick_q
);

  localparam int CW = $clog2(MS_CYC + 1);
  localparam int SW = $clog2(MS_PER_S + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(MS_CYC - 1);
  localparam logic [SW-1:0] MS_LAST = SW'(MS_PER_S - 1);

  logic [CW-1:0] cyc_q;
  logic [SW-1:0] ms_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cyc_q <= '0;
      ms_tick_q <= 1'b0;
    end
    else
    begin
      ms_tick_q <= (cyc_q == CYC_LAST);
      cyc_q <= (cyc_q == CYC_LAST) ? '0 : cyc_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ms_q <= '0;
      s_tick_q <= 1'b0;
    end
    else
    begin
      s_tick_q <= ms_tick_q && (ms_q == MS_LAST);
      if (ms_tick_q)
        ms_q <= (ms_q == MS_LAST) ? '0 : ms_q + 1'b1;
    end
  end

endmodule : pmit_tick_gen

// File: hw/pmit_top.sv
// second-level status mirrors and idle timer 1 of the power manager
// assumes a synchronous config port and single-cycle event pulses
// Overview of operation
// - trap bit 7 flags an SMI from a trapped video I/O access.
// - trap bit 5 flags an SMI from a secondary hard disk access.
// - trap bit 4 flags secondary disk idle expiry; bit 6 reserved.
// - trap bit 3 flags an SMI from a keyboard or mouse access.
// - trap bit 2 flags an SMI from a serial or parallel access.
// - trap bit 1 flags floppy access, bit 0 primary disk access.
// - trap mirror reads keep status; reads at F6h clear it.
// - misc mirror reads keep status; reads at F7h clear it.
// - every second-level event also sets top-level status bit 0.
// - misc bits 7, 6, 5 flag transitions on general pins 2, 1, 0.
// - pin transition counts only if selected, input and SMI enabled.
// - misc bit 4 follows the lid switch pin level when selected.
// - misc bit 3 flags lid transitions when input and lid-selected.
// - misc bit 2 flags a rising edge on codec SDATA_IN.
// - misc bit 1 flags the RTC interrupt, only in 3V suspend.
// - misc bit 0 flags a toggle of the ACPI timer top bit.
// - timer 1 loads its 8-bit count when enabled, 8 or 16 bits wide.
// - in 16-bit mode the count is shifted left eight bits.
// - while running, selected activity events reload timer 1.
// - timer 1 counts ticks; expiry sets top bit 9 and requests an SMI.
// - after expiry timer 1 stops until re-enabled or rewritten.
// - control bit 7 picks 1 s ticks (0) or 1 ms ticks (1).
// - control bits 6, 5, 4 reload on user device 3, 2, 1 access.
`timescale 1ns/100ps
module pmit_top #(
  parameter int MS_CYC = pmit_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // configuration port
  input wire pmit_pkg::pmit_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata_q,
  output logic cfg_rvalid_q,
  // device trap events
  input wire pmit_pkg::pmit_trap_evt_t trap_evt,
  // pins and their configuration
  input wire logic [2:0] general_pin,
  input wire logic lid_switch_pin,
  input wire pmit_pkg::pmit_pin_cfg_t pin_cfg,
  input wire logic codec_sdata_in,
  input wire logic codec_smi_en,
  input wire logic rtc_alarm_interrupt,
  input wire logic suspend_3v,
  input wire logic acpi_tmr_msb,
  input wire logic acpi_smi_en,
  // idle timer 1 controls and activity pulses
  input wire logic tmr1_en,
  input wire logic tmr1_wide,
  input wire logic [6:0] activity,
  // status towards the top level
  output logic top0_set_q,
  output logic tmr1_expire_q,
  output logic smi_req_q
);

  logic ms_tick;
  logic s_tick;
  logic [7:0] trap_set;
  logic [7:0] misc_set;
  logic [7:0] trap_stat;
  logic [7:0] misc_stat;
  logic trap_clr;
  logic misc_clr;
  logic [2:0] gp_prev_q;
  logic lid_prev_q;
  logic codec_prev_q;
  logic rtc_prev_q;
  logic acpi_prev_q;
  logic lid_pos_q;
  logic [2:0] gp_ok;
  logic [7:0] count_q;
  logic [7:0] ctrl_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic run_q;
  logic run_d;
  logic en_prev_q;
  logic en_rise;
  logic cnt_wr;
  logic reload;
  logic tick;
  logic expire_d;
  logic [7:0] load_src;
  logic [15:0] load_val;
  logic [7:0] rdata_d;

  pmit_tick_gen #(
    .MS_CYC(MS_CYC),
    .MS_PER_S(pmit_pkg::MS_PER_S)
  ) u_ticks (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ms_tick_q(ms_tick),
    .s_tick_q(s_tick)
  );

  // ---- trap status mirror
  always_comb
  begin
    trap_set = 8'h00;
    trap_set[pmit_pkg::TRAP_VIDEO_BIT] = trap_evt.video;
    trap_set[pmit_pkg::TRAP_SEC_HD_BIT] = trap_evt.sec_hd;
    trap_set[pmit_pkg::TRAP_SEC_IDLE_BIT] = trap_evt.sec_hd_idle;
    trap_set[pmit_pkg::TRAP_KBD_BIT] = trap_evt.kbd_mouse;
    trap_set[pmit_pkg::TRAP_PAR_SER_BIT] = trap_evt.par_ser;
    trap_set[pmit_pkg::TRAP_FLOPPY_BIT] = trap_evt.floppy;
    trap_set[pmit_pkg::TRAP_PRI_HD_BIT] = trap_evt.pri_hd;
  end

  // only the counterpart indices clear
  assign trap_clr = cfg_req.rd && cfg_req.addr == pmit_pkg::TRAP_CLEAR_IDX;
  assign misc_clr = cfg_req.rd && cfg_req.addr == pmit_pkg::MISC_CLEAR_IDX;

  pmit_sticky #(
    .W(8)
  ) u_trap (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(trap_set),
    .clr(trap_clr),
    .q(trap_stat)
  );

  // ---- miscellaneous event status mirror
  assign gp_ok = pin_cfg.gp_sel & ~pin_cfg.gp_dir & pin_cfg.gp_smi_en;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      gp_prev_q <= 3'h0;
      lid_prev_q <= 1'b0;
      codec_prev_q <= 1'b0;
      rtc_prev_q <= 1'b0;
      acpi_prev_q <= 1'b0;
    end
    else
    begin
      gp_prev_q <= general_pin;
      lid_prev_q <= lid_switch_pin;
      codec_prev_q <= codec_sdata_in;
      rtc_prev_q <= rtc_alarm_interrupt;
      acpi_prev_q <= acpi_tmr_msb;
    end
  end

  always_comb
  begin
    misc_set = 8'h00;
    for (int i = 0; i < 3; i++)
      misc_set[pmit_pkg::MISC_GP0_BIT + i] =
        gp_ok[i] && (general_pin[i] != gp_prev_q[i]);
    misc_set[pmit_pkg::MISC_LID_SMI_BIT] = !pin_cfg.lid_dir &&
      pin_cfg.lid_sel && (lid_switch_pin != lid_prev_q);
    misc_set[pmit_pkg::MISC_CODEC_BIT] = codec_smi_en &&
      codec_sdata_in && !codec_prev_q;
    misc_set[pmit_pkg::MISC_RTC_BIT] = suspend_3v &&
      rtc_alarm_interrupt && !rtc_prev_q;
    misc_set[pmit_pkg::MISC_ACPI_BIT] = acpi_smi_en &&
      (acpi_tmr_msb != acpi_prev_q);
  end

  pmit_sticky #(
    .W(8)
  ) u_misc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set(misc_set),
    .clr(misc_clr),
    .q(misc_stat)
  );

  // lid position is a live level, not a sticky flag
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lid_pos_q <= 1'b0;
    else
      lid_pos_q <= pin_cfg.lid_sel && lid_switch_pin;
  end

  // ---- top-level status and SMI request
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      top0_set_q <= 1'b0;
      smi_req_q <= 1'b0;
    end
    else
    begin
      top0_set_q <= |trap_set || |misc_set;
      smi_req_q <= |trap_set || |misc_set || expire_d;
    end
  end

  // ---- timer 1 registers
  assign cnt_wr = cfg_req.wr && cfg_req.addr == pmit_pkg::TMR1_COUNT_IDX;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      count_q <= pmit_pkg::TMR1_COUNT_RST;
      ctrl_q <= pmit_pkg::TMR1_CTRL_RST;
    end
    else if (cfg_req.wr)
    begin
      if (cfg_req.addr == pmit_pkg::TMR1_COUNT_IDX)
        count_q <= cfg_req.wdata;
      if (cfg_req.addr == pmit_pkg::TMR1_CTRL_IDX)
        ctrl_q <= cfg_req.wdata;
    end
  end

  // ---- timer 1 counter
  assign en_rise = tmr1_en && !en_prev_q;
  assign load_src = cnt_wr ? cfg_req.wdata : count_q;
  assign load_val = tmr1_wide ? {load_src, 8'h00}
                              : {8'h00, load_src};
  assign reload = en_rise || (tmr1_en && cnt_wr) || (run_q &&
    |(activity & ctrl_q[pmit_pkg::CTRL_RETRIG_W-1:0]));
  assign tick = ctrl_q[pmit_pkg::CTRL_TIMEBASE_BIT] ? ms_tick
                                                    : s_tick;

  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    expire_d = 1'b0;
    if (!tmr1_en)
      run_d = 1'b0;
    else if (reload)
    begin
      cnt_d = load_val;
      run_d = 1'b1;
    end
    else if (run_q && tick)
    begin
      if (cnt_q <= 16'h0001)
      begin
        cnt_d = 16'h0000;
        run_d = 1'b0;
        expire_d = 1'b1;
      end
      else
        cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      en_prev_q <= 1'b0;
      tmr1_expire_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      en_prev_q <= tmr1_en;
      tmr1_expire_q <= expire_d;
    end
  end

  // ---- read path, one cycle after the request
  always_comb
  begin
    rdata_d = pmit_pkg::STATUS_RST;
    unique case (cfg_req.addr)
      pmit_pkg::TRAP_MIRROR_IDX, pmit_pkg::TRAP_CLEAR_IDX:
        rdata_d = trap_stat;
      pmit_pkg::MISC_MIRROR_IDX, pmit_pkg::MISC_CLEAR_IDX:
      begin
        rdata_d = misc_stat;
        rdata_d[pmit_pkg::MISC_LID_POS_BIT] = lid_pos_q;
      end
      pmit_pkg::TMR1_COUNT_IDX:
        rdata_d = count_q;
      pmit_pkg::TMR1_CTRL_IDX:
        rdata_d = ctrl_q;
      default:
        rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cfg_rdata_q <= 8'h00;
      cfg_rvalid_q <= 1'b0;
    end
    else
    begin
      cfg_rvalid_q <= cfg_req.rd;
      if (cfg_req.rd)
        cfg_rdata_q <= rdata_d;
    end
  end

  // ---- checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence load_seq;
    en_rise && !cnt_wr;
  endsequence

  sequence wide_load_seq;
    en_rise && !cnt_wr && tmr1_wide;
  endsequence

  mirror_read_keeps_a: assert property (
    (cfg_req.rd && cfg_req.addr == pmit_pkg::TRAP_MIRROR_IDX
      && trap_set == 8'h00) |=> $stable(trap_stat))
    else $error("trap mirror read changed status");

  trap_clear_read_a: assert property (
    (trap_clr && trap_set == 8'h00) |=> trap_stat == 8'h00)
    else $error("trap counterpart read did not clear");

  misc_clear_read_a: assert property (
    (misc_clr && misc_set == 8'h00) |=>
      (misc_stat & 8'hEF) == 8'h00)
    else $error("misc counterpart read did not clear");

  top_level_set_a: assert property (
    $rose(trap_stat[pmit_pkg::TRAP_VIDEO_BIT]) |-> top0_set_q)
    else $error("trap event missing top-level status");

  gpio_qualified_a: assert property (
    $rose(misc_stat[pmit_pkg::MISC_GP0_BIT]) |-> $past(gp_ok[0]))
    else $error("unqualified pin transition flagged");

  lid_level_a: assert property (
    pin_cfg.lid_sel |=> lid_pos_q == $past(lid_switch_pin))
    else $error("lid position does not follow pin");

  rtc_suspend_a: assert property (
    $rose(misc_stat[pmit_pkg::MISC_RTC_BIT]) |-> $past(suspend_3v))
    else $error("rtc status set outside suspend");

  timer_load_a: assert property (
    load_seq |=> run_q && cnt_q == $past(load_val))
    else $error("timer not loaded on enable");

  wide_low_zero_a: assert property (
    wide_load_seq |=> cnt_q[7:0] == 8'h00)
    else $error("wide mode low byte not zero");

  expire_stops_a: assert property (
    (tmr1_expire_q && !reload) |-> !run_q ##1 (!run_q || $past(reload)))
    else $error("timer ran on after expiry");

endmodule : pmit_top

// File: verif/pmit_top_tb_top.sv
// testbench for the status mirrors and idle timer 1 block
// assumes pmit_top built with a short millisecond prescale
`timescale 1ns/100ps
module pmit_top_tb_top;
  localparam int MS = 10;
  localparam int SEC = pmit_pkg::MS_PER_S * MS;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  pmit_pkg::pmit_cfg_req_t cfg_req = '0;
  logic [7:0] cfg_rdata_q;
  logic cfg_rvalid_q;
  pmit_pkg::pmit_trap_evt_t trap_evt = '0;
  logic [2:0] general_pin = 3'h0;
  logic lid_switch_pin = 1'b0;
  pmit_pkg::pmit_pin_cfg_t pin_cfg = '0;
  logic codec_sdata_in = 1'b0;
  logic codec_smi_en = 1'b0;
  logic rtc_alarm_interrupt = 1'b0;
  logic suspend_3v = 1'b0;
  logic acpi_tmr_msb = 1'b0;
  logic acpi_smi_en = 1'b0;
  logic tmr1_en = 1'b0;
  logic tmr1_wide = 1'b0;
  logic [6:0] activity = 7'h00;
  logic top0_set_q;
  logic tmr1_expire_q;
  logic smi_req_q;
  int fail_count = 0;
  int num_checks = 0;

  always #5 clk_sys = ~clk_sys;

  pmit_top #(
    .MS_CYC(MS)
  ) pmit_top_inst (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .cfg_req(cfg_req),
    .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q),
    .trap_evt(trap_evt),
    .general_pin(general_pin),
    .lid_switch_pin(lid_switch_pin),
    .pin_cfg(pin_cfg),
    .codec_sdata_in(codec_sdata_in),
    .codec_smi_en(codec_smi_en),
    .rtc_alarm_interrupt(rtc_alarm_interrupt),
    .suspend_3v(suspend_3v),
    .acpi_tmr_msb(acpi_tmr_msb),
    .acpi_smi_en(acpi_smi_en),
    .tmr1_en(tmr1_en),
    .tmr1_wide(tmr1_wide),
    .activity(activity),
    .top0_set_q(top0_set_q),
    .tmr1_expire_q(tmr1_expire_q),
    .smi_req_q(smi_req_q)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_bit(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk_bit

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cfg_req.wr = 1'b1;
    cfg_req.addr = a;
    cfg_req.wdata = d;
    @(negedge clk_sys);
    cfg_req.wr = 1'b0;
  endtask : wr

  // read answers one cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    cfg_req.rd = 1'b1;
    cfg_req.addr = a;
    @(negedge clk_sys);
    cfg_req.rd = 1'b0;
    chk_bit(cfg_rvalid_q, 1'b1);
    chk8(cfg_rdata_q, exp);
  endtask : rd

  task automatic t_regs();
    wr(8'h86, 8'hFF);
    wr(8'h87, 8'hFF);
    rd(8'h86, 8'h00);
    rd(8'h87, 8'h00);
    wr(8'h88, 8'hA5);
    wr(8'h89, 8'h5A);
    rd(8'h88, 8'hA5);
    rd(8'h89, 8'h5A);
    rd(8'h40, 8'h00);
    $display("register test done");
  endtask : t_regs

  task automatic t_trap();
    logic [7:0] e;
    for (int i = 0; i < 7; i++)
    begin
      e = (i == 6) ? 8'h80 : 8'(1 << i);
      @(negedge clk_sys);
      trap_evt = 7'(1 << i);
      @(negedge clk_sys);
      trap_evt = '0;
      chk_bit(top0_set_q, 1'b1);
      chk_bit(smi_req_q, 1'b1);
      @(negedge clk_sys);
      chk_bit(top0_set_q, 1'b0);
      rd(8'h86, e);
      rd(8'h86, e);
      rd(8'hF6, e);
      rd(8'h86, 8'h00);
    end
    $display("trap test done");
  endtask : t_trap

  task automatic t_misc();
    @(negedge clk_sys);
    pin_cfg.gp_sel = 3'h7;
    pin_cfg.gp_smi_en = 3'h1;
    @(negedge clk_sys);
    general_pin = 3'h7;
    rtc_alarm_interrupt = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(8'h87, 8'h20);
    rd(8'h87, 8'h20);
    rd(8'hF7, 8'h20);
    rd(8'h87, 8'h00);
    @(negedge clk_sys);
    pin_cfg.gp_smi_en = 3'h7;
    pin_cfg.gp_dir = 3'h4;
    pin_cfg.lid_sel = 1'b1;
    rtc_alarm_interrupt = 1'b0;
    suspend_3v = 1'b1;
    codec_smi_en = 1'b1;
    acpi_smi_en = 1'b1;
    @(negedge clk_sys);
    general_pin = 3'h0;
    lid_switch_pin = 1'b1;
    codec_sdata_in = 1'b1;
    rtc_alarm_interrupt = 1'b1;
    acpi_tmr_msb = 1'b1;
    @(negedge clk_sys);
    chk_bit(top0_set_q, 1'b1);
    repeat (2) @(negedge clk_sys);
    rd(8'hF7, 8'h7F);
    rd(8'h87, 8'h10);
    @(negedge clk_sys);
    pin_cfg.lid_dir = 1'b1;
    pin_cfg.gp_dir = 3'h0;
    pin_cfg.gp_sel = 3'h6;
    @(negedge clk_sys);
    lid_switch_pin = 1'b0;
    codec_sdata_in = 1'b0;
    general_pin = 3'h7;
    repeat (3) @(negedge clk_sys);
    rd(8'h87, 8'hC0);
    $display("misc event test done");
  endtask : t_misc

  // restart timer 1 from disabled with a fresh count and control
  task automatic arm(input logic [7:0] cnt, input logic [7:0] ctl,
                     input logic w);
    @(negedge clk_sys);
    tmr1_en = 1'b0;
    tmr1_wide = w;
    wr(8'h88, cnt);
    wr(8'h89, ctl);
    @(negedge clk_sys);
    tmr1_en = 1'b1;
  endtask : arm

  task automatic expire_in(input int lo, input int hi);
    int n;
    n = 0;
    while (tmr1_expire_q !== 1'b1 && n <= hi)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk_bit(n > lo && n <= hi, 1'b1);
    chk_bit(smi_req_q, 1'b1);
  endtask : expire_in

  task automatic pulse_act(input logic [6:0] v);
    @(negedge clk_sys);
    activity = v;
    @(negedge clk_sys);
    activity = 7'h00;
  endtask : pulse_act

  task automatic t_timer();
    int n;
    logic [7:0] ctl;
    arm(8'h03, 8'h80, 1'b0);
    expire_in(2 * MS, 3 * MS + 4);
    n = 0;
    repeat (5 * MS)
    begin
      @(negedge clk_sys);
      if (tmr1_expire_q !== 1'b0)
        n++;
    end
    chk8(8'(n), 8'h00);
    wr(8'h88, 8'h02);
    expire_in(MS - 2, 2 * MS + 4);
    arm(8'h01, 8'h80, 1'b1);
    expire_in(255 * MS, 256 * MS + 4);
    arm(8'h02, 8'h00, 1'b0);
    expire_in(SEC, 2 * SEC + 4);
    for (int i = 0; i < 7; i++)
    begin
      ctl = 8'h80 | 8'(1 << i);
      arm(8'h03, ctl, 1'b0);
      repeat (MS + MS / 2) @(negedge clk_sys);
      pulse_act(7'h7F & ~7'(1 << i));
      expire_in(0, 2 * MS);
      arm(8'h03, ctl, 1'b0);
      repeat (MS + MS / 2) @(negedge clk_sys);
      pulse_act(7'(1 << i));
      expire_in(2 * MS - 1, 3 * MS + 4);
    end
    $display("timer test done");
  endtask : t_timer

  initial
  begin
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_regs();
    t_trap();
    t_misc();
    t_timer();
    test_done();
  end

  // cut a hang short well past the expected run length
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    test_done();
  end
endmodule : pmit_top_tb_top
